// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the touch interrupt and pin setup block.
// Assumes: Zero wait state slave; events and starts are one-cycle pulses.
// Notes:   One task per scenario; a watchdog bounds the run.
`include "touch_adc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_top;
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  logic                            hsel = 1'b0;
  logic                            hwrite = 1'b0;
  logic [1:0]                      htrans = 2'h0;
  logic [31:0]                     haddr = 32'h0000_0000;
  logic [31:0]                     hwdata = 32'h0000_0000;
  logic [31:0]                     hrdata;
  logic [31:0]                     rd;
  logic                            hready;
  logic                            hresp;
  logic [1:0]                      mask = 2'h1;
  logic                            active = 1'b0;
  logic                            start = 1'b0;
  logic [2:0]                      chan = 3'h0;
  touch_adc_pkg::touch_events_type evt;
  logic [9:0]                      sar;
  logic                            irq_req;
  logic [1:0]                      irq_lvl;
  logic                            done;
  logic                            busy;
  logic [2:0]                      adc_ch;
  logic                            vref_on;
  logic                            vref_ok;
  touch_adc_pkg::pin_mode_type     pins;
  int                              fails = 0;
  int                              n_compared = 0;
  localparam logic [31:0] addr_en   = {14'h0000, `IDX_IRQ_ENABLE, 2'h0};
  localparam logic [31:0] addr_flag = {14'h0000, `IDX_FACTOR_FLAGS, 2'h0};
  localparam logic [31:0] addr_pin  = {14'h0000, `IDX_PIN_SELECT, 2'h0};
  localparam logic [31:0] addr_ctl  = {14'h0000, `IDX_CONTROL, 2'h0};
  localparam logic [31:0] addr_data = {14'h0000, `IDX_ADC_DATA, 2'h0};

  // The clock never stops, so detection is never cut short.
  always #12.5 clk = ~clk;

  touch_adc_irq_and_pin_setup touch_adc_irq_and_pin_setup_inst (
    .CLK_IN              (clk),
    .RESET_IN            (rst),
    .HSEL_IN             (hsel),
    .HADDR_IN            (haddr),
    .HTRANS_IN           (htrans),
    .HWRITE_IN           (hwrite),
    .HSIZE_IN            (3'h2),
    .HWDATA_IN           (hwdata),
    .HREADY_IN           (hready),
    .HRDATA_OUT          (hrdata),
    .HREADYOUT_OUT       (hready),
    .HRESP_OUT           (hresp),
    .TOUCH_EVT_IN        (evt),
    .CPU_IRQ_MASK_IN     (mask),
    .TOUCH_ACTIVE_IN     (active),
    .CONV_START_IN       (start),
    .CONV_CHANNEL_IN     (chan),
    .SAR_RESULT_IN       (sar),
    .TOUCH_IRQ_REQ_OUT   (irq_req),
    .TOUCH_IRQ_LEVEL_OUT (irq_lvl),
    .ADC_DONE_EVT_OUT    (done),
    .ADC_BUSY_OUT        (busy),
    .ADC_CHANNEL_OUT     (adc_ch),
    .VREF_ON_OUT         (vref_on),
    .VREF_SETTLED_OUT    (vref_ok),
    .PIN_MODE_OUT        (pins)
  );

  touch_partner touch_partner_inst (
    .clk_in   (clk),
    .busy_in  (busy),
    .level_in (10'h2A5),
    .evt_out  (evt),
    .sar_out  (sar)
  );

  // Every wait on the bus has no bound of its own; the watchdog ends a hang.
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic t_regs();
    `CHK(pins, {8'h03, 2'h0})
    xfer(1'b0, addr_en, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, addr_flag, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b1, addr_en, 32'hFFFF_FFFF, rd);
    xfer(1'b0, addr_en, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0060)
    xfer(1'b1, addr_en, 32'h0000_0000, rd);
    xfer(1'b1, 32'h0000_0800, 32'hFFFF_FFFF, rd);
    xfer(1'b0, 32'h0000_0800, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    $display("t_regs done");
  endtask

  task automatic t_flags();
    touch_partner_inst.fire(2'h2);
    repeat (2) tick();
    `CHK(irq_req, 1'b0)
    xfer(1'b0, addr_flag, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0040)
    // The event lands in the data phase of a clearing write; the set wins.
    fork
      xfer(1'b1, addr_flag, 32'h0000_0020, rd);
      begin
        @(posedge clk);
        touch_partner_inst.fire(2'h1);
      end
    join
    xfer(1'b0, addr_flag, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0060)
    xfer(1'b1, addr_flag, 32'h0000_0040, rd);
    xfer(1'b0, addr_flag, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0020)
    xfer(1'b1, addr_flag, 32'h0000_0020, rd);
    xfer(1'b0, addr_flag, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    $display("t_flags done");
  endtask

  task automatic t_irq();
    xfer(1'b1, addr_en, 32'h0000_0040, rd);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, addr_ctl, 32'(p), rd);
      touch_partner_inst.fire(2'h2);
      repeat (2) tick();
      `CHK(irq_req, (p > 1))
      `CHK(irq_lvl, p[1:0])
      xfer(1'b1, addr_flag, 32'h0000_0040, rd);
    end
    mask <= 2'h3;
    touch_partner_inst.fire(2'h2);
    repeat (2) tick();
    `CHK(irq_req, 1'b0)
    xfer(1'b1, addr_flag, 32'h0000_0040, rd);
    mask <= 2'h2;
    touch_partner_inst.fire(2'h1);
    repeat (2) tick();
    `CHK(irq_req, 1'b0)
    xfer(1'b1, addr_en, 32'h0000_0060, rd);
    tick();
    `CHK(irq_req, 1'b1)
    xfer(1'b1, addr_flag, 32'h0000_0020, rd);
    tick();
    `CHK(irq_req, 1'b0)
    $display("t_irq done");
  endtask

  task automatic t_pins();
    xfer(1'b1, addr_pin, 32'h0000_00C0, rd);
    xfer(1'b1, addr_ctl, 32'h0000_000C, rd);
    tick();
    `CHK(pins, {8'h03, 2'h3})
    xfer(1'b1, addr_ctl, 32'h0000_0004, rd);
    tick();
    `CHK(pins, {8'h83, 2'h1})
    xfer(1'b1, addr_ctl, 32'h0000_0000, rd);
    tick();
    `CHK(pins, {8'hC3, 2'h0})
    xfer(1'b0, addr_pin, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_00C0)
    $display("t_pins done");
  endtask

  task automatic t_conv();
    int nb;
    int nd;
    nb = 0;
    nd = 0;
    active <= 1'b0;
    start <= 1'b1;
    chan <= 3'h5;
    @(posedge clk);
    start <= 1'b0;
    #1;
    nb += int'(busy);
    for (int i = 0; i < 460; i++) begin
      tick();
      nb += int'(busy);
      nd += int'(done);
      start <= (i == 20);
      chan <= (i == 20) ? 3'h3 : 3'h5;
    end
    `CHK(nb, 441)
    `CHK(nd, 1)
    `CHK(adc_ch, 3'h5)
    xfer(1'b0, addr_data, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_52A5)
    $display("t_conv done");
  endtask

  task automatic t_vref();
    int n;
    n = 0;
    // One wait step is sixteen cycles, well over three slow clock periods.
    xfer(1'b1, addr_ctl, 32'h0000_0110, rd);
    active <= 1'b1;
    tick();
    `CHK(vref_on, 1'b1)
    while (vref_ok !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    `CHK(n, 16)
    active <= 1'b0;
    tick();
    `CHK({vref_on, vref_ok}, 2'h0)
    $display("t_vref done");
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_flags();
    t_irq();
    t_pins();
    t_conv();
    t_vref();
    print_verdict();
  end

  // The whole run needs under two thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire

// ===== dv/touch_partner.sv
// Purpose: Far-side model of the touch panel and the analog result lines.
// Assumes: Events are one-cycle pulses on the block's clock.
// Notes:   Result lines float outside conversions, so they toggle then.
`timescale 1ns/100ps
`default_nettype none

module touch_partner (
  input  wire logic                       clk_in,
  input  wire logic                       busy_in,
  input  wire logic [9:0]                 level_in,
  output touch_adc_pkg::touch_events_type evt_out,
  output logic      [9:0]                 sar_out
);
  initial evt_out = 2'h0;
  initial sar_out = 10'h155;

  // Held steady through a conversion, since the result must not move then.
  always @(posedge clk_in) sar_out <= busy_in ? level_in : ~sar_out;

  task automatic fire(input touch_adc_pkg::touch_events_type e);
    evt_out <= e;
    @(posedge clk_in);
    evt_out <= 2'h0;
  endtask
endmodule // touch_partner

`default_nettype wire

// ===== src/touch_adc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: AHB-Lite word registers, byte address is four times the index.
// Notes:   Definitions only.
`ifndef TOUCH_ADC_DEFS_SVH
`define TOUCH_ADC_DEFS_SVH

`define IDX_W             16
`define IDX_IRQ_ENABLE    16'hFF26
`define IDX_FACTOR_FLAGS  16'h0F2A
`define IDX_PIN_SELECT    16'h0100
`define IDX_CONTROL       16'h0101
`define IDX_ADC_DATA      16'h0102
`define ADDR_HIGH_LSB     18
`define ADDR_IDX_LSB      2

`define BIT_PEN_DOWN      6
`define BIT_COORD_UPDATE  5
`define CTL_PRIO_LSB      0
`define CTL_DAC_LSB       2
`define CTL_VREF_AUTO     4
`define CTL_WAIT_LSB      8
`define DATA_BUSY_BIT     15
`define DATA_CHAN_LSB     12

`define RST_IRQ_ENABLE    2'h0
`define RST_FACTOR_FLAGS  2'h0
`define RST_PIN_SELECT    8'h00
`define RST_PRIO          2'h0
`define RST_DAC_SELECT    2'h0
`define RST_WAIT          4'h0
`define TOUCH_PIN_MASK    8'h03

`define CONV_TIME_NS      11000
`define CLK_PERIOD_NS     25
`define WAIT_UNIT_CYCLES  16

`endif

// ===== src/touch_adc_irq_and_pin_setup.sv
// Purpose: Touch interrupt enables and flags, converter timing, pin modes.
// Assumes: Event and start inputs come from logic on CLK_IN.
// Notes:   Zero wait state AHB-Lite slave; response is always OKAY.
//
// What this block does
// - Two read/write enables gate pen-down and coordinate-update requests.
// - Reset clears both interrupt enables.
// - One flag per touch source, set by its event, reads 1 while pending.
// - Pen-down detection sets the pen-down flag.
// - Writing averaged coordinates sets the coordinate-update flag.
// - Request goes out only if enabled and priority exceeds the CPU mask.
// - Flags set regardless of enable and priority.
// - Writing 1 clears a flag, writing 0 leaves it.
// - Reset clears both flags.
// - With automatic reference control, the wait is the settling time.
// - Successive approximation, 10-bit result register, eight channels.
// - A conversion takes at least 11 us.
// - Each completed conversion raises an event.
// - One analog-input select bit per shared pin switches it to analog.
// - On the two shared output pins the analog output wins.
// - Reset leaves shared pins as ports except the two touch inputs.
// - The two touch pins are fixed analog inputs by option.
// - Two-bit priority, 0 means none, 1 to 3 select levels.
`include "touch_adc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module touch_adc_irq_and_pin_setup (
  input  wire logic                           CLK_IN,
  input  wire logic                           RESET_IN,
  input  wire logic                           HSEL_IN,
  input  wire logic [31:0]                    HADDR_IN,
  input  wire logic [1:0]                     HTRANS_IN,
  input  wire logic                           HWRITE_IN,
  input  wire logic [2:0]                     HSIZE_IN,
  input  wire logic [31:0]                    HWDATA_IN,
  input  wire logic                           HREADY_IN,
  output logic      [31:0]                    HRDATA_OUT,
  output logic                                HREADYOUT_OUT,
  output logic                                HRESP_OUT,
  input  wire touch_adc_pkg::touch_events_type TOUCH_EVT_IN,
  input  wire logic [1:0]                     CPU_IRQ_MASK_IN,
  input  wire logic                           TOUCH_ACTIVE_IN,
  input  wire logic                           CONV_START_IN,
  input  wire logic [2:0]                     CONV_CHANNEL_IN,
  input  wire logic [9:0]                     SAR_RESULT_IN,
  output logic                                TOUCH_IRQ_REQ_OUT,
  output logic      [1:0]                     TOUCH_IRQ_LEVEL_OUT,
  output logic                                ADC_DONE_EVT_OUT,
  output logic                                ADC_BUSY_OUT,
  output logic      [2:0]                     ADC_CHANNEL_OUT,
  output logic                                VREF_ON_OUT,
  output logic                                VREF_SETTLED_OUT,
  output touch_adc_pkg::pin_mode_type         PIN_MODE_OUT
);

  localparam int CONV_CYCLES =
    (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [8:0] CONV_LAST = 9'(CONV_CYCLES - 1);
  localparam logic [7:0] TOUCH_MASK = `TOUCH_PIN_MASK;

  // Bus address phase capture.
  logic                  addr_ok;
  logic                  wr_pend_r;
  logic [`IDX_W-1:0]     wr_idx_r;
  logic [`IDX_W-1:0]     ap_idx;
  logic                  wr_en_reg;
  logic                  wr_flag_reg;
  logic                  wr_pin_reg;
  logic                  wr_ctl_reg;

  // Registers.
  logic [1:0]            irq_en_r;
  logic [1:0]            irq_en_nxt;
  logic [1:0]            flags_r;
  logic [1:0]            flags_nxt;
  logic [7:0]            pin_sel_r;
  logic [7:0]            pin_sel_nxt;
  logic [1:0]            prio_r;
  logic [1:0]            dac_sel_r;
  logic                  vref_auto_r;
  logic [3:0]            wait_r;
  logic [11:0]           ctl_nxt;
  logic [9:0]            adc_data_r;
  logic [31:0]           rd_word;

  // Converter and reference timing, pin analog enables.
  touch_adc_pkg::conv_state_type conv_state_r;
  logic [8:0]            conv_cnt_r;
  logic [9:0]            sar_meta_r;
  logic [9:0]            sar_sync_r;
  logic [7:0]            settle_cnt_r;
  logic [7:0]            settle_len;
  logic [7:0]            ana_en;

  assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN &&
                   (HADDR_IN[31:`ADDR_HIGH_LSB] == '0);
  assign ap_idx  = HADDR_IN[`ADDR_HIGH_LSB-1:`ADDR_IDX_LSB];

  assign wr_en_reg   = wr_pend_r && (wr_idx_r == `IDX_IRQ_ENABLE);
  assign wr_flag_reg = wr_pend_r && (wr_idx_r == `IDX_FACTOR_FLAGS);
  assign wr_pin_reg  = wr_pend_r && (wr_idx_r == `IDX_PIN_SELECT);
  assign wr_ctl_reg  = wr_pend_r && (wr_idx_r == `IDX_CONTROL);

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= '0;
    end else begin
      wr_pend_r <= addr_ok && HWRITE_IN;
      wr_idx_r  <= ap_idx;
    end
  end

  // Next values feed both the flops and the read mux, so a read right after
  // a write sees the written value.
  always_comb begin
    irq_en_nxt  = irq_en_r;
    pin_sel_nxt = pin_sel_r;
    ctl_nxt     = {wait_r, 3'b000, vref_auto_r, dac_sel_r, prio_r};
    if (wr_en_reg) begin
      irq_en_nxt = {HWDATA_IN[`BIT_PEN_DOWN],
                    HWDATA_IN[`BIT_COORD_UPDATE]};
    end
    if (wr_pin_reg) begin
      pin_sel_nxt = HWDATA_IN[7:0];
    end
    if (wr_ctl_reg) begin
      ctl_nxt = HWDATA_IN[11:0];
    end
    // Set wins over a same-cycle clear so no event is lost.
    flags_nxt = flags_r;
    if (wr_flag_reg) begin
      flags_nxt = flags_r & ~{HWDATA_IN[`BIT_PEN_DOWN],
                              HWDATA_IN[`BIT_COORD_UPDATE]};
    end
    flags_nxt = flags_nxt | {TOUCH_EVT_IN.pen_down,
                             TOUCH_EVT_IN.coord_update};
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      irq_en_r <= `RST_IRQ_ENABLE;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      flags_r <= `RST_FACTOR_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pin_sel_r   <= `RST_PIN_SELECT;
      prio_r      <= `RST_PRIO;
      dac_sel_r   <= `RST_DAC_SELECT;
      vref_auto_r <= 1'b0;
      wait_r      <= `RST_WAIT;
    end else begin
      pin_sel_r   <= pin_sel_nxt;
      prio_r      <= ctl_nxt[`CTL_PRIO_LSB +: 2];
      dac_sel_r   <= ctl_nxt[`CTL_DAC_LSB +: 2];
      vref_auto_r <= ctl_nxt[`CTL_VREF_AUTO];
      wait_r      <= ctl_nxt[`CTL_WAIT_LSB +: 4];
    end
  end

  always_comb begin
    rd_word = '0;
    case (ap_idx)
      `IDX_IRQ_ENABLE: begin
        rd_word[`BIT_PEN_DOWN]     = irq_en_nxt[1];
        rd_word[`BIT_COORD_UPDATE] = irq_en_nxt[0];
      end
      `IDX_FACTOR_FLAGS: begin
        rd_word[`BIT_PEN_DOWN]     = flags_nxt[1];
        rd_word[`BIT_COORD_UPDATE] = flags_nxt[0];
      end
      `IDX_PIN_SELECT: rd_word[7:0] = pin_sel_nxt;
      `IDX_CONTROL:    rd_word[11:0] = ctl_nxt;
      `IDX_ADC_DATA: begin
        rd_word[9:0]                = adc_data_r;
        rd_word[`DATA_CHAN_LSB +: 3] = ADC_CHANNEL_OUT;
        rd_word[`DATA_BUSY_BIT]     = ADC_BUSY_OUT;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      HRDATA_OUT    <= '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      HRDATA_OUT    <= (addr_ok && !HWRITE_IN) ? rd_word : '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // The request holds while the flag stays set, so software must clear it
  // before another touch request can be told apart.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      TOUCH_IRQ_REQ_OUT   <= 1'b0;
      TOUCH_IRQ_LEVEL_OUT <= `RST_PRIO;
    end else begin
      TOUCH_IRQ_REQ_OUT   <= (|(flags_r & irq_en_r)) &&
                             (prio_r > CPU_IRQ_MASK_IN);
      TOUCH_IRQ_LEVEL_OUT <= prio_r;
    end
  end

  // The result pins are sampled through two flops before use.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sar_meta_r <= '0;
      sar_sync_r <= '0;
    end else begin
      sar_meta_r <= SAR_RESULT_IN;
      sar_sync_r <= sar_meta_r;
    end
  end

  // Starts arrive only from the owner of the converter; a start while busy
  // is ignored rather than queued.
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      conv_state_r     <= touch_adc_pkg::CONV_IDLE;
      conv_cnt_r       <= '0;
      adc_data_r       <= '0;
      ADC_CHANNEL_OUT  <= '0;
      ADC_BUSY_OUT     <= 1'b0;
      ADC_DONE_EVT_OUT <= 1'b0;
    end else begin
      ADC_DONE_EVT_OUT <= 1'b0;
      case (conv_state_r)
        touch_adc_pkg::CONV_IDLE: begin
          if (CONV_START_IN) begin
            conv_state_r    <= touch_adc_pkg::CONV_BUSY;
            conv_cnt_r      <= '0;
            ADC_CHANNEL_OUT <= CONV_CHANNEL_IN;
            ADC_BUSY_OUT    <= 1'b1;
          end
        end
        touch_adc_pkg::CONV_BUSY: begin
          if (conv_cnt_r == CONV_LAST) begin
            conv_state_r <= touch_adc_pkg::CONV_DONE;
          end else begin
            conv_cnt_r <= conv_cnt_r + 9'd1;
          end
        end
        touch_adc_pkg::CONV_DONE: begin
          adc_data_r       <= sar_sync_r;
          ADC_DONE_EVT_OUT <= 1'b1;
          ADC_BUSY_OUT     <= 1'b0;
          conv_state_r     <= touch_adc_pkg::CONV_IDLE;
        end
        default: conv_state_r <= touch_adc_pkg::CONV_IDLE;
      endcase
    end
  end

  // A wait setting too short for the slow clock gives an unsettled reference.
  assign settle_len = {wait_r, 4'b0000};

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      VREF_ON_OUT      <= 1'b0;
      VREF_SETTLED_OUT <= 1'b0;
      settle_cnt_r     <= '0;
    end else if (vref_auto_r && TOUCH_ACTIVE_IN) begin
      VREF_ON_OUT <= 1'b1;
      if (settle_cnt_r >= settle_len) begin
        VREF_SETTLED_OUT <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r + 8'd1;
      end
    end else begin
      VREF_ON_OUT      <= 1'b0;
      VREF_SETTLED_OUT <= 1'b0;
      settle_cnt_r     <= '0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      if (gi >= 6) begin : g_dac
        assign ana_en[gi] = (pin_sel_r[gi] | TOUCH_MASK[gi]) &
                            ~dac_sel_r[gi-6];
      end else begin : g_port
        assign ana_en[gi] = pin_sel_r[gi] | TOUCH_MASK[gi];
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PIN_MODE_OUT.analog_in_en <= `TOUCH_PIN_MASK;
      PIN_MODE_OUT.dac_out_en   <= `RST_DAC_SELECT;
    end else begin
      PIN_MODE_OUT.analog_in_en <= ana_en;
      PIN_MODE_OUT.dac_out_en   <= dac_sel_r;
    end
  end

  // Checks.
  logic [8:0] busy_len_r;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      busy_len_r <= '0;
    end else if (ADC_BUSY_OUT) begin
      busy_len_r <= busy_len_r + 9'd1;
    end else begin
      busy_len_r <= '0;
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_enable_write: assert property (
    wr_en_reg |=> irq_en_r == $past({HWDATA_IN[`BIT_PEN_DOWN],
                                     HWDATA_IN[`BIT_COORD_UPDATE]}))
    else $error("Enable bits did not take the written value.");

  a_pen_flag_set: assert property (
    TOUCH_EVT_IN.pen_down |=> flags_r[1])
    else $error("Pen-down event did not set its flag.");

  a_coord_flag_set: assert property (
    TOUCH_EVT_IN.coord_update && !irq_en_r[0] |=> flags_r[0])
    else $error("Coordinate event did not set its flag.");

  a_clear_by_one: assert property (
    wr_flag_reg && HWDATA_IN[`BIT_PEN_DOWN] && !TOUCH_EVT_IN.pen_down
      |=> !flags_r[1])
    else $error("Writing one did not clear the pen-down flag.");

  a_zero_keeps: assert property (
    wr_flag_reg && !HWDATA_IN[`BIT_COORD_UPDATE] && flags_r[0]
      |=> flags_r[0])
    else $error("Writing zero changed the coordinate flag.");

  a_irq_gating: assert property (
    ##1 TOUCH_IRQ_REQ_OUT == $past((|(flags_r & irq_en_r)) &&
                                   prio_r > CPU_IRQ_MASK_IN))
    else $error("Interrupt request does not follow flag, enable and level.");

  a_conv_length: assert property (
    ADC_DONE_EVT_OUT |-> busy_len_r == 9'(CONV_CYCLES + 1))
    else $error("Conversion finished at the wrong time.");

  a_done_pulse: assert property (
    ADC_BUSY_OUT ##1 !ADC_BUSY_OUT |-> ADC_DONE_EVT_OUT ##1 !ADC_DONE_EVT_OUT)
    else $error("Conversion end without a one-cycle done event.");

  a_dac_wins: assert property (
    PIN_MODE_OUT.dac_out_en[1] |-> !PIN_MODE_OUT.analog_in_en[7])
    else $error("Pin seven is analog input while its output is on.");

  a_touch_fixed: assert property (
    (PIN_MODE_OUT.analog_in_en[1:0] & 2'b11) == 2'b11)
    else $error("Touch input pins left analog mode.");

  a_vref_settle: assert property (
    $rose(VREF_ON_OUT) && wait_r != 4'h0 |-> !VREF_SETTLED_OUT [*8])
    else $error("Reference reported settled before the wait time.");

  c_pen_irq:   cover property (TOUCH_EVT_IN.pen_down ##2 TOUCH_IRQ_REQ_OUT);
  c_conv_done: cover property (ADC_DONE_EVT_OUT);
  c_set_clear: cover property (wr_flag_reg && TOUCH_EVT_IN.coord_update);

endmodule // touch_adc_irq_and_pin_setup

`default_nettype wire

// ===== src/touch_adc_pkg.sv
// Purpose: Types shared by the touch interrupt and pin setup block.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only.
package touch_adc_pkg;

  typedef struct packed {
    logic [7:0] analog_in_en;
    logic [1:0] dac_out_en;
  } pin_mode_type;

  typedef struct packed {
    logic pen_down;
    logic coord_update;
  } touch_events_type;

  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_BUSY = 3'b010,
    CONV_DONE = 3'b100
  } conv_state_type;

endpackage
